// file: frt_pkg.sv
package frt_pkg;

  // ************************************************************
  // Register map (byte addresses, one byte register per word)
  // ************************************************************
  localparam logic [7:0] A_CTRL_ONE  = 8'h00;
  localparam logic [7:0] A_CTRL_TWO  = 8'h04;
  localparam logic [7:0] A_STATUS    = 8'h08;
  localparam logic [7:0] A_CAP1_HI   = 8'h0C;
  localparam logic [7:0] A_CAP1_LO   = 8'h10;
  localparam logic [7:0] A_CMP1_HI   = 8'h14;
  localparam logic [7:0] A_CMP1_LO   = 8'h18;
  localparam logic [7:0] A_CAP2_HI   = 8'h1C;
  localparam logic [7:0] A_CAP2_LO   = 8'h20;
  localparam logic [7:0] A_CMP2_HI   = 8'h24;
  localparam logic [7:0] A_CMP2_LO   = 8'h28;
  localparam logic [7:0] A_CNT_HI    = 8'h2C;
  localparam logic [7:0] A_CNT_LO    = 8'h30;
  localparam logic [7:0] A_ACNT_HI   = 8'h34;
  localparam logic [7:0] A_ACNT_LO   = 8'h38;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int C1_CAP_IE  = 7;
  localparam int C1_CMP_IE  = 6;
  localparam int C1_OVF_IE  = 5;
  localparam int C1_OLVL2   = 2;
  localparam int C1_IEDG1   = 1;
  localparam int C1_OLVL1   = 0;
  localparam int C2_OC1E    = 7;
  localparam int C2_OC2E    = 6;
  localparam int C2_OPM     = 5;
  localparam int C2_PWM     = 4;
  localparam int C2_CS_HI   = 3;
  localparam int C2_CS_LO   = 2;
  localparam int C2_IEDG2   = 1;
  localparam int C2_EXTERNAL_EDGE_SELECT   = 0;
  localparam int ST_ICF1    = 7;
  localparam int ST_OCF1    = 6;
  localparam int ST_TOF     = 5;
  localparam int ST_ICF2    = 4;
  localparam int ST_OCF2    = 3;

  // ************************************************************
  // Clock select codes, divider ends, reset values
  // ************************************************************
  localparam logic [1:0]  CS_DIV4   = 2'h0;
  localparam logic [1:0]  CS_DIV2   = 2'h1;
  localparam logic [1:0]  CS_DIV8   = 2'h2;
  localparam logic [1:0]  CS_EXT    = 2'h3;
  localparam logic [2:0]  DIV2_LAST = 3'h1;
  localparam logic [2:0]  DIV4_LAST = 3'h3;
  localparam logic [2:0]  DIV8_LAST = 3'h7;
  localparam logic [15:0] CNT_RESET = 16'hFFFC;
  localparam logic [15:0] CNT_TOP   = 16'hFFFF;
  localparam logic [15:0] CMP_RESET = 16'h8000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } frt_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } frt_apb_rsp_type;

  typedef struct packed {
    logic [7:0]       ctrl_one;
    logic [7:0]       ctrl_two;
    logic [15:0]      count;
    logic [2:0]       div;
    logic             tick;
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] cap;
    logic [1:0]       icf;
    logic [1:0]       ocf;
    logic             overflow_flag;
    logic [1:0]       arm_icf;
    logic [1:0]       arm_ocf;
    logic             arm_tof;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_inh;
    logic [1:0]       cnt_lock;
    logic [1:0][7:0]  cnt_buf;
    logic [1:0]       cpin;
    logic [1:0][2:0]  cap_s;
    logic [1:0]       cap_lvl;
    logic [2:0]       ext_s;
    logic             ext_lvl;
    logic             irq;
    frt_apb_rsp_type  rsp;
  } frt_state_type;

endpackage

// file: frt_timer.sv
`timescale 1ns/1ps
`default_nettype none

module frt_timer
  import frt_pkg::*;
(
  input  wire logic            core_clk,        // CPU clock, 25 MHz
  input  wire logic            rst,             // Synchronous reset, high
  input  wire frt_apb_req_type apb_req,         // APB request
  output var  frt_apb_rsp_type apb_rsp,         // APB response
  input  wire logic            global_irq_mask, // CPU interrupt mask bit
  input  wire logic            halt_mode,       // Halt: counter frozen
  input  wire logic [1:0]      capture_pin,     // Capture inputs
  input  wire logic            external_clock_pin, // External count clock
  output logic      [1:0]      compare_pin,     // Compare outputs
  output logic      [1:0]      compare_pin_oe,  // Compare pin enables
  output logic                 timer_irq        // Timer interrupt request
);

  frt_state_type q;
  frt_state_type d;

  logic [1:0]  clk_sel;
  logic        acc;
  logic        tick;
  logic        ovf_ev;
  logic        ext_edge;
  logic        one_pulse;
  logic        pwm;
  logic [1:0]  edge_sel;
  logic [1:0]  olvl;
  logic [1:0]  pin_en;
  logic [1:0]  cap_edge;
  logic [15:0] target;
  logic [7:0]  rd;
  logic        miss;

  assign apb_rsp        = q.rsp;
  assign compare_pin    = q.cpin;
  assign compare_pin_oe = {q.ctrl_two[C2_OC2E], q.ctrl_two[C2_OC1E]};
  assign timer_irq      = q.irq;

  assign clk_sel   = q.ctrl_two[C2_CS_HI:C2_CS_LO];
  assign one_pulse = q.ctrl_two[C2_OPM];
  assign pwm       = q.ctrl_two[C2_PWM];
  assign edge_sel  = {q.ctrl_two[C2_IEDG2], q.ctrl_one[C1_IEDG1]};
  assign olvl      = {q.ctrl_one[C1_OLVL2], q.ctrl_one[C1_OLVL1]};
  assign pin_en    = {q.ctrl_two[C2_OC2E], q.ctrl_two[C2_OC1E]};

  always_comb begin
    d        = q;
    acc      = apb_req.psel & apb_req.penable & ~q.rsp.pready;
    tick     = 1'b0;
    ovf_ev   = 1'b0;
    ext_edge = 1'b0;
    cap_edge = 2'h0;
    target   = 16'h0000;
    rd       = 8'h00;
    miss     = 1'b0;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // A level is taken only when the second and third stages agree
    for (int i = 0; i < 2; i++) begin
      d.cap_s[i] = {q.cap_s[i][1:0], capture_pin[i]};
      if (q.cap_s[i][1] == q.cap_s[i][2]) begin
        d.cap_lvl[i] = q.cap_s[i][2];
      end
      // Pins are watched whatever the port direction elsewhere
      cap_edge[i] = (d.cap_lvl[i] != q.cap_lvl[i])
                  & (d.cap_lvl[i] == edge_sel[i]);
    end
    d.ext_s = {q.ext_s[1:0], external_clock_pin};
    if (q.ext_s[1] == q.ext_s[2]) begin
      d.ext_lvl = q.ext_s[2];
    end
    // Edges closer than the sync depth would merge
    ext_edge = (d.ext_lvl != q.ext_lvl)
             & (d.ext_lvl == q.ctrl_two[C2_EXTERNAL_EDGE_SELECT]);

    // ************************************************************
    // Prescaler and counter
    // ************************************************************
    if (!halt_mode) begin
      if (clk_sel == CS_EXT) begin
        tick  = ext_edge;
        d.div = 3'h0;
      end else if ((clk_sel == CS_DIV2 && q.div >= DIV2_LAST) ||
                   (clk_sel == CS_DIV4 && q.div >= DIV4_LAST) ||
                   (clk_sel == CS_DIV8 && q.div >= DIV8_LAST)) begin
        tick  = 1'b1;
        d.div = 3'h0;
      end else begin
        d.div = q.div + 3'h1;
      end
    end
    d.tick = tick;
    // Single-clock design: the count moves on the CPU clock edge only
    if (tick) begin
      d.count = q.count + 16'h0001;
      ovf_ev  = (q.count == CNT_TOP);
    end

    // ************************************************************
    // Register access
    // ************************************************************
    // Side effects land at the edge that raises pready
    d.rsp.pready  = acc;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata  = 32'h0000_0000;
    if (acc) begin
      case (apb_req.paddr)
        A_CTRL_ONE: begin
          rd = q.ctrl_one;
          if (apb_req.pwrite) begin
            d.ctrl_one = apb_req.pwdata[7:0];
          end
        end
        A_CTRL_TWO: begin
          rd = q.ctrl_two;
          if (apb_req.pwrite) begin
            d.ctrl_two = apb_req.pwdata[7:0];
          end
        end
        A_STATUS: begin
          rd[ST_ICF1] = q.icf[0];
          rd[ST_OCF1] = q.ocf[0];
          rd[ST_TOF]  = q.overflow_flag;
          rd[ST_ICF2] = q.icf[1];
          rd[ST_OCF2] = q.ocf[1];
          if (!apb_req.pwrite) begin
            // First step of every flag clear
            d.arm_tof = q.arm_tof | q.overflow_flag;
            d.arm_icf = q.arm_icf | q.icf;
            d.arm_ocf = q.arm_ocf | q.ocf;
          end
        end
        A_CAP1_HI, A_CAP2_HI: begin
          rd = q.cap[apb_req.paddr == A_CAP2_HI][15:8];
          if (!apb_req.pwrite) begin
            d.cap_lock[apb_req.paddr == A_CAP2_HI] = 1'b1;
          end
        end
        A_CAP1_LO, A_CAP2_LO: begin
          for (int i = 0; i < 2; i++) begin
            if ((apb_req.paddr == A_CAP2_LO) == (i == 1)) begin
              rd = q.cap[i][7:0];
              if (!apb_req.pwrite) begin
                d.cap_lock[i] = 1'b0;
              end
              if (q.arm_icf[i]) begin
                d.icf[i]     = 1'b0;
                d.arm_icf[i] = 1'b0;
              end
            end
          end
        end
        A_CMP1_HI, A_CMP2_HI: begin
          for (int i = 0; i < 2; i++) begin
            if ((apb_req.paddr == A_CMP2_HI) == (i == 1)) begin
              rd = q.cmp[i][15:8];
              if (apb_req.pwrite) begin
                d.cmp[i][15:8] = apb_req.pwdata[7:0];
                d.cmp_inh[i]   = 1'b1;
              end
            end
          end
        end
        A_CMP1_LO, A_CMP2_LO: begin
          for (int i = 0; i < 2; i++) begin
            if ((apb_req.paddr == A_CMP2_LO) == (i == 1)) begin
              rd = q.cmp[i][7:0];
              if (apb_req.pwrite) begin
                d.cmp[i][7:0] = apb_req.pwdata[7:0];
                d.cmp_inh[i]  = 1'b0;
              end
              if (q.arm_ocf[i]) begin
                d.ocf[i]     = 1'b0;
                d.arm_ocf[i] = 1'b0;
              end
            end
          end
        end
        A_CNT_HI, A_ACNT_HI: begin
          rd = q.count[15:8];
          if (!apb_req.pwrite) begin
            // Buffer is refreshed only by the first high read
            for (int j = 0; j < 2; j++) begin
              if ((apb_req.paddr == A_ACNT_HI) == (j == 1) &&
                  !q.cnt_lock[j]) begin
                d.cnt_buf[j]  = q.count[7:0];
                d.cnt_lock[j] = 1'b1;
              end
            end
          end
        end
        A_CNT_LO, A_ACNT_LO: begin
          for (int j = 0; j < 2; j++) begin
            if ((apb_req.paddr == A_ACNT_LO) == (j == 1)) begin
              rd = q.cnt_lock[j] ? q.cnt_buf[j] : q.count[7:0];
              if (!apb_req.pwrite) begin
                d.cnt_lock[j] = 1'b0;
              end
            end
          end
          if (apb_req.pwrite) begin
            d.count = CNT_RESET;
            d.div   = 3'h0;
          end
          // Only the main low byte finishes the overflow clear
          if (apb_req.paddr == A_CNT_LO && q.arm_tof) begin
            d.overflow_flag     = 1'b0;
            d.arm_tof = 1'b0;
          end
        end
        default: begin
          miss = 1'b1;
        end
      endcase
      d.rsp.pslverr = miss;
      d.rsp.prdata  = {24'h00_0000, rd};
    end

    // ************************************************************
    // Hardware events (after the bus, so a set beats a clear)
    // ************************************************************
    if (ovf_ev) begin
      d.overflow_flag = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (cap_edge[i] && !d.cap_lock[i] &&
          !(i == 0 && (one_pulse || pwm))) begin
        d.cap[i] = q.count;
        d.icf[i] = 1'b1;
      end
      // Slow clocks see the match one count late
      if (clk_sel == CS_DIV2) begin
        target = q.cmp[i];
      end else begin
        target = q.cmp[i] + 16'h0001;
      end
      if (q.tick && q.count == target && !q.cmp_inh[i]) begin
        if (!pwm && !(i == 0 && one_pulse)) begin
          d.ocf[i] = 1'b1;
        end
        if (pin_en[i]) begin
          d.cpin[i] = olvl[i];
        end
      end
    end

    // Flags are sticky, so a masked request stays pending
    d.irq = ~global_irq_mask & (
              (q.ctrl_one[C1_OVF_IE] & q.overflow_flag) |
              (q.ctrl_one[C1_CAP_IE] & (|q.icf)) |
              (q.ctrl_one[C1_CMP_IE] & (|q.ocf)));

    if (rst) begin
      d        = '0;
      d.count  = CNT_RESET;
      d.cmp[0] = CMP_RESET;
      d.cmp[1] = CMP_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    q <= d;
  end

endmodule

`default_nettype wire

// file: frt_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Pin-side partner: capture levels and a gated external clock
// ************************************************************
module frt_pins_model
  import frt_pkg::*;
(
  input  wire logic       core_clk,           // CPU clock
  input  wire logic [1:0] cap_lvl,            // Requested capture levels
  input  wire logic       ext_go,             // Load a burst of edges
  input  wire logic [7:0] ext_n,              // Rising edges in burst
  output logic      [1:0] capture_pin,        // Capture pins
  output logic            external_clock_pin, // External clock pin
  output logic            ext_busy            // Burst in progress
);
  logic [7:0] left_q;
  logic [1:0] ph_q;
  initial begin
    left_q = 8'h00;
    ph_q = 2'h0;
    capture_pin = 2'h0;
    external_clock_pin = 1'b0;
  end
  // Clock stands low between bursts; edges three cycles apart
  always @(posedge core_clk) begin
    capture_pin <= cap_lvl;
    if (ext_go) begin
      left_q <= ext_n;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h2) begin
        ph_q <= 2'h0;
        external_clock_pin <= ~external_clock_pin;
        if (external_clock_pin) begin
          left_q <= left_q - 8'h01;
        end
      end
    end
  end
  assign ext_busy = (left_q != 8'h00);
endmodule
`default_nettype wire

// file: frt_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module frt_timer_chk
  import frt_pkg::*;
(
  input wire logic            core_clk,           // Clock
  input wire logic            rst,                // Reset
  input wire frt_apb_req_type apb_req,            // APB request
  input wire frt_apb_rsp_type apb_rsp,            // APB response
  input wire logic            global_irq_mask,    // Mask
  input wire logic            halt_mode,          // Halt
  input wire logic [1:0]      capture_pin,        // Capture pins
  input wire logic            external_clock_pin, // External clock
  input wire logic [1:0]      compare_pin,        // Compare pins
  input wire logic [1:0]      compare_pin_oe,     // Compare enables
  input wire logic            timer_irq           // Interrupt
);
  // ************************************************************
  // Port relations
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  a_ready_follows: assert property (acc |=> apb_rsp.pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_idle_quiet: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
    else $error("response not zero when idle");
  a_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_bad_addr: assert property (acc && (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > A_ACNT_LO)
    |=> apb_rsp.pslverr) else $error("unmapped access not refused");
  a_oe_follow: assert property (acc && apb_req.pwrite && apb_req.paddr == A_CTRL_TWO |=>
    compare_pin_oe == {$past(apb_req.pwdata[C2_OC2E]), $past(apb_req.pwdata[C2_OC1E])})
    else $error("pin enables do not follow control write");
  a_irq_masked: assert property ($past(global_irq_mask) |-> !timer_irq)
    else $error("interrupt while masked");
  a_reset_pins: assert property ($fell(rst) |-> compare_pin == 2'h0 &&
    compare_pin_oe == 2'h0 && !timer_irq) else $error("outputs not cleared by reset");
endmodule
bind frt_timer frt_timer_chk i_frt_timer_chk (.core_clk, .rst, .apb_req, .apb_rsp,
  .global_irq_mask, .halt_mode, .capture_pin, .external_clock_pin, .compare_pin,
  .compare_pin_oe, .timer_irq);
`default_nettype wire

// file: test_free_running_capture_compare_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_free_running_capture_compare_timer
  import frt_pkg::*;
;
  logic            core_clk, rst, global_irq_mask, halt_mode, ext_go, ext_busy;
  logic            external_clock_pin, timer_irq, serr;
  logic [1:0]      cap_lvl, capture_pin, compare_pin, compare_pin_oe;
  logic [7:0]      ext_n, h, l, h2, lv, c;
  frt_apb_req_type apb_req;
  frt_apb_rsp_type apb_rsp;
  int              errors, total_checks, k, w;
  frt_timer i_frt_timer (.core_clk, .rst, .apb_req, .apb_rsp, .global_irq_mask, .halt_mode,
    .capture_pin, .external_clock_pin, .compare_pin, .compare_pin_oe, .timer_irq);
  frt_pins_model i_frt_pins_model (.core_clk, .cap_lvl, .ext_go, .ext_n, .capture_pin,
    .external_clock_pin, .ext_busy);
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic wr_n, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_n, paddr: a, pwdata: {24'h0, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata[7:0];
    serr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    apb(1'b0, a, 8'h00, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    apb(1'b1, a, d, t);
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] t;
    rd(a, t);
    chk(t, e);
  endtask
  task automatic run(input int n);
    ext_n <= 8'(n);
    ext_go <= 1'b1;
    @(posedge core_clk);
    ext_go <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 400 && ext_busy; i++) @(posedge core_clk);
    if (ext_busy) begin
      errors++;
      $display("BAD %0t external clock burst did not end", $time);
    end
    repeat (6) @(posedge core_clk);
  endtask
  task automatic pulse0();
    cap_lvl <= 2'h0;
    repeat (6) @(posedge core_clk);
    cap_lvl <= 2'h1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic summarize();
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ************************************************************
  // Clock, watchdog, sequence
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    global_irq_mask = 1'b0;
    halt_mode = 1'b0;
    ext_go = 1'b0;
    ext_n = 8'h00;
    cap_lvl = 2'h2;
    apb_req = '0;
    errors = 0;
    total_checks = 0;
    void'($urandom(32'hE3D80C0A));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    ck(A_CMP1_HI, 8'h80);
    ck(A_CMP1_LO, 8'h00);
    ck(A_CMP2_HI, 8'h80);
    ck(A_CMP2_LO, 8'h00);
    ck(8'h3C, 8'h00);
    chk(serr, 1'b1);
    ck(8'h02, 8'h00);
    chk(serr, 1'b1);
    // Buffered read while the count moves, halt freezes it
    wr(A_CTRL_TWO, 8'h04);
    halt_mode <= 1'b1;
    rd(A_CNT_HI, h);
    rd(A_CNT_LO, l);
    rd(A_CNT_HI, h2);
    w = $urandom_range(60, 20);
    halt_mode <= 1'b0;
    repeat (w) @(posedge core_clk);
    halt_mode <= 1'b1;
    rd(A_CNT_HI, h2);
    ck(A_CNT_LO, l);
    rd(A_CNT_LO, lv);
    rd(A_CNT_HI, h2);
    ck(A_CNT_LO, lv);
    k = 16'({h2, lv} - {h, l});
    chk(k >= w / 2 - 1 && k <= w / 2 + 1, 1'b1);
    halt_mode <= 1'b0;
    wr(A_CTRL_ONE, 8'h20);
    for (int e = 0; e < 2; e++) begin
      wr(A_CTRL_TWO, {4'h0, CS_EXT, 1'b0, e[0]});
      rd(A_STATUS, h);
      wr(A_CNT_LO, 8'h00);
      k = $urandom_range(20, 4);
      run(k);
      ck(A_STATUS, 8'h20);
      chk(timer_irq, 1'b1);
      rd(A_ACNT_HI, h);
      rd(A_ACNT_LO, l);
      chk({h, l}, 16'(CNT_RESET + k));
      ck(A_ACNT_LO, l);
      ck(A_STATUS, 8'h20);
      global_irq_mask <= 1'b1;
      rd(A_CNT_LO, l);
      chk(timer_irq, 1'b0);
      ck(A_STATUS, 8'h00);
      global_irq_mask <= 1'b0;
    end
    // Captures on a frozen count, then lock and mode refusals
    wr(A_CTRL_ONE, 8'h82);
    wr(A_CTRL_TWO, 8'h0C);
    wr(A_CNT_LO, 8'h00);
    cap_lvl <= 2'h1;
    repeat (8) @(posedge core_clk);
    ck(A_STATUS, 8'h90);
    chk(timer_irq, 1'b1);
    ck(A_CAP1_HI, 8'hFF);
    ck(A_CAP1_LO, 8'hFC);
    ck(A_CAP2_HI, 8'hFF);
    ck(A_CAP2_LO, 8'hFC);
    ck(A_STATUS, 8'h00);
    run(2);
    rd(A_CAP1_HI, h);
    pulse0();
    ck(A_STATUS, 8'h00);
    ck(A_CAP1_LO, 8'hFC);
    wr(A_CTRL_TWO, 8'h2C);
    pulse0();
    ck(A_STATUS, 8'h00);
    // Compare match one count late under the external clock
    c = 8'($urandom_range(8, 1));
    wr(A_CTRL_ONE, 8'h41);
    wr(A_CTRL_TWO, 8'h8C);
    wr(A_CMP1_HI, 8'h00);
    wr(A_CMP1_LO, c);
    wr(A_CNT_LO, 8'h00);
    run(c + 4);
    ck(A_STATUS, 8'h20);
    chk(compare_pin, 2'h0);
    run(1);
    ck(A_STATUS, 8'h60);
    chk(compare_pin, 2'h1);
    chk(timer_irq, 1'b1);
    ck(A_CMP1_LO, c);
    ck(A_STATUS, 8'h20);
    summarize();
  end
endmodule
`default_nettype wire
